// *** src/bwp_cfg.svh ***
// Constants of the byte/word parallel host port: widths, field positions, reset values.
// Assumes inclusion by the port package and design modules; holds definitions only.
`ifndef BWP_CFG_SVH
`define BWP_CFG_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define BWP_DATA_W 12
`define BWP_LOW_W 8
`define BWP_TOP_W 3
`define BWP_CHAN_W 3
`define BWP_NIB_W 4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BWP_HI_CHAN_LSB 4
`define BWP_SHARED_BIT 8
`define BWP_TOP_LSB 9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BWP_RST_WORD 12'h000
`define BWP_RST_LOW 8'h00
`define BWP_RST_CHAN 3'h0

`endif

// *** src/bwp_pkg.sv ***
// Types shared by the byte/word parallel host port modules.
// Assumes bwp_cfg.svh is reachable by its bare name.
`include "bwp_cfg.svh"

package bwp_pkg;

  // ----------------------------------------------------------------
  // Transfer state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BWP_IDLE  = 3'b001,
    BWP_READ  = 3'b010,
    BWP_WRITE = 3'b100
  } bwp_state_t;

  typedef logic [`BWP_DATA_W-1:0] bwp_word_t;

endpackage

// *** src/bwp_lane.sv ***
// One group of three-state bus pins: registered output data and output enable.
// Assumes the enclosing port computes the wanted level and enable each cycle.
`timescale 1ns/10ps

module bwp_lane #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rstSyncN,
  input wire logic [W-1:0] dataNext,
  input wire logic enNext,
  output logic [W-1:0] pinOut,
  output logic [W-1:0] pinOe
);

  typedef struct packed {
    logic [W-1:0] data;
    logic [W-1:0] oe;
  } bwp_lane_t;

  bwp_lane_t lane_reg;
  bwp_lane_t lane_next;

  // ----------------------------------------------------------------
  // Pin registers
  // ----------------------------------------------------------------
  // The enable fans out per bit so every pin has its own flip-flop.
  always_comb begin
    lane_next.data = dataNext;
    lane_next.oe = {W{enNext}};
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      lane_reg <= '0;
    end else begin
      lane_reg <= lane_next;
    end
  end

  assign pinOut = lane_reg.data;
  assign pinOe = lane_reg.oe;

endmodule

// *** src/bwp_port.sv ***
// Host-facing parallel data port of a multichannel converter, word or byte wide.
// Assumes host strobes are synchronous to clk; conversion result comes from the core.
`timescale 1ns/10ps
`include "bwp_cfg.svh"

module bwp_port
  import bwp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic wordMode,
  input wire logic [`BWP_LOW_W-1:0] busLowBitsIn,
  output logic [`BWP_LOW_W-1:0] busLowBitsOut,
  output logic [`BWP_LOW_W-1:0] busLowBitsOe,
  input wire logic sharedPinEightIn,
  output logic sharedPinEightOut,
  output logic sharedPinEightOe,
  input wire logic [`BWP_TOP_W-1:0] busTopBitsIn,
  output logic [`BWP_TOP_W-1:0] busTopBitsOut,
  output logic [`BWP_TOP_W-1:0] busTopBitsOe,
  input wire logic [`BWP_DATA_W-1:0] resultWord,
  input wire logic [`BWP_CHAN_W-1:0] resultChan,
  output logic [`BWP_DATA_W-1:0] regWrData,
  output logic regWrStrobe,
  output logic readDone
);

  typedef struct packed {
    bwp_state_t state;
    bwp_word_t rdWord;
    logic [`BWP_CHAN_W-1:0] rdChan;
    bwp_word_t wrWord;
    logic [`BWP_LOW_W-1:0] lowHold;
    logic wrWide;
    logic wrHigh;
    bwp_word_t outData;
    logic outStrobe;
    logic outReadDone;
  } bwp_port_t;

  bwp_port_t port_reg;
  bwp_port_t port_next;
  logic [1:0] rstSync_reg;
  logic rstSyncN;
  logic readAct;
  logic writeAct;
  logic upperSel;
  bwp_word_t wordNow;
  logic [`BWP_CHAN_W-1:0] chanNow;
  logic [`BWP_LOW_W-1:0] lowNext;
  logic sharedNext;
  logic [`BWP_TOP_W-1:0] topNext;
  logic lowEn;
  logic sharedEn;
  logic topEn;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Reset asserts at once but releases two edges late, so no flip-flop
  // leaves reset on a marginal edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end

  // Only the second stage is read, so a late first stage never reaches the design.
  assign rstSyncN = rstSync_reg[1];

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  // A read wins if a broken host pulls both strobes, since the device
  // then drives and no register is corrupted by bus contention.
  assign readAct = !csN && !rdN;
  assign writeAct = !csN && !wrN && rdN;
  assign upperSel = !wordMode && sharedPinEightIn;

  // The result is frozen at the start of a read so it cannot change
  // under the host while the strobe is low.
  assign wordNow = (port_reg.state == BWP_READ) ? port_reg.rdWord : resultWord;
  assign chanNow = (port_reg.state == BWP_READ) ? port_reg.rdChan : resultChan;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Wanted levels and enables; the lanes register them.
  always_comb begin
    lowEn = readAct;
    sharedEn = readAct && wordMode;
    topEn = readAct && wordMode;
    sharedNext = wordNow[`BWP_SHARED_BIT];
    topNext = wordNow[`BWP_DATA_W-1:`BWP_TOP_LSB];
    if (upperSel) begin
      // Bit seven of the upper byte reads as zero.
      lowNext = {1'b0, chanNow, wordNow[`BWP_DATA_W-1:`BWP_LOW_W]};
    end else begin
      lowNext = wordNow[`BWP_LOW_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Transfer state
  // ----------------------------------------------------------------
  // Write data is sampled every cycle of the strobe; the value seen in
  // the last active cycle is what the host held up to the rising edge.
  always_comb begin
    port_next = port_reg;
    port_next.outStrobe = 1'b0;
    port_next.outReadDone = 1'b0;
    unique case (port_reg.state)
      BWP_IDLE: begin
        if (readAct) begin
          port_next.state = BWP_READ;
          port_next.rdWord = resultWord;
          port_next.rdChan = resultChan;
        end else if (writeAct) begin
          port_next.state = BWP_WRITE;
        end
      end
      BWP_READ: begin
        if (!readAct) begin
          port_next.state = BWP_IDLE;
          port_next.outReadDone = 1'b1;
        end
      end
      BWP_WRITE: begin
        if (!writeAct) begin
          port_next.state = BWP_IDLE;
          port_next.outStrobe = port_reg.wrWide || port_reg.wrHigh;
          if (port_reg.wrWide) begin
            port_next.outData = port_reg.wrWord;
          end else if (port_reg.wrHigh) begin
            port_next.outData = {port_reg.wrWord[`BWP_NIB_W-1:0], port_reg.lowHold};
          end else begin
            port_next.lowHold = port_reg.wrWord[`BWP_LOW_W-1:0];
          end
        end
      end
      default: begin
        port_next.state = BWP_IDLE;
      end
    endcase
    // Bits four to seven of an upper byte write are ignored, not checked.
    if (writeAct) begin
      port_next.wrWord = {busTopBitsIn, sharedPinEightIn, busLowBitsIn};
      port_next.wrWide = wordMode;
      port_next.wrHigh = upperSel;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      port_reg.state <= BWP_IDLE;
      port_reg.rdWord <= `BWP_RST_WORD;
      port_reg.rdChan <= `BWP_RST_CHAN;
      port_reg.wrWord <= `BWP_RST_WORD;
      port_reg.lowHold <= `BWP_RST_LOW;
      port_reg.wrWide <= 1'b0;
      port_reg.wrHigh <= 1'b0;
      port_reg.outData <= `BWP_RST_WORD;
      port_reg.outStrobe <= 1'b0;
      port_reg.outReadDone <= 1'b0;
    end else begin
      port_reg <= port_next;
    end
  end

  // Core-side results leave straight from the state register, with no gate in front.
  assign regWrData = port_reg.outData;
  assign regWrStrobe = port_reg.outStrobe;
  assign readDone = port_reg.outReadDone;

  // ----------------------------------------------------------------
  // Pin lanes
  // ----------------------------------------------------------------
  bwp_lane #(.W(`BWP_LOW_W)) lowLane (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .dataNext(lowNext),
    .enNext(lowEn),
    .pinOut(busLowBitsOut),
    .pinOe(busLowBitsOe)
  );

  bwp_lane #(.W(1)) sharedLane (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .dataNext(sharedNext),
    .enNext(sharedEn),
    .pinOut(sharedPinEightOut),
    .pinOe(sharedPinEightOe)
  );

  bwp_lane #(.W(`BWP_TOP_W)) topLane (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .dataNext(topNext),
    .enNext(topEn),
    .pinOut(busTopBitsOut),
    .pinOe(busTopBitsOe)
  );

endmodule

// *** dv/bwp_port_checker.sv ***
// Concurrent checks on the pins of the parallel host port.
// Assumes it is bound into bwp_port and sees only its ports.
`timescale 1ns/10ps
module bwp_port_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic wordMode,
  input wire logic [7:0] busLowBitsOut,
  input wire logic [7:0] busLowBitsOe,
  input wire logic sharedPinEightIn,
  input wire logic sharedPinEightOut,
  input wire logic sharedPinEightOe,
  input wire logic [2:0] busTopBitsOut,
  input wire logic [2:0] busTopBitsOe,
  input wire logic [11:0] resultWord,
  input wire logic [2:0] resultChan,
  input wire logic regWrStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic rdNow;
  logic [11:0] oeAll;
  logic [11:0] outAll;
  logic rdPrev;
  logic [11:0] snapWord;
  logic [2:0] snapChan;
  logic [11:0] expWord;
  logic [2:0] expChan;
  // The port freezes the result on the first read cycle, so the expected word follows that copy.
  always_ff @(posedge clk) begin
    rdPrev <= rdNow;
    if (rdNow && !rdPrev) begin
      snapWord <= resultWord;
      snapChan <= resultChan;
    end
  end
  assign expWord = (rdNow && !rdPrev) ? resultWord : snapWord;
  assign expChan = (rdNow && !rdPrev) ? resultChan : snapChan;
  // Whole bus views keep each check to a single comparison.
  assign rdNow = !csN && !rdN;
  assign oeAll = {busTopBitsOe, sharedPinEightOe, busLowBitsOe};
  assign outAll = {busTopBitsOut, sharedPinEightOut, busLowBitsOut};
  a_bus_float: assert property (
    $past(csN || rdN) |-> !oeAll) else $error("bus driven while idle");
  a_read_drive: assert property (
    $past(rdNow) |-> &busLowBitsOe) else $error("read not driven");
  a_byte_top_float: assert property (
    !wordMode |-> !sharedPinEightOe && !busTopBitsOe) else $error("byte mode top driven");
  a_word_ext: assert property (
    $past(rdNow && wordMode) |-> &oeAll) else $error("word mode top not driven");
  a_word_data: assert property (
    $past(rdNow && wordMode) |-> outAll == $past(expWord)) else $error("word data");
  a_low_byte: assert property (
    $past(rdNow && !wordMode && !sharedPinEightIn) |->
    busLowBitsOut == 8'($past(expWord))) else $error("low byte data");
  a_high_byte: assert property (
    $past(rdNow && !wordMode && sharedPinEightIn) |->
    busLowBitsOut == {1'b0, $past(expChan), 4'($past(expWord) >> 8)})
    else $error("high byte data");
  a_wr_pulse: assert property (
    $rose(wrN) && !$past(csN) && wordMode |-> ##[1:2] regWrStrobe ##1 !regWrStrobe)
    else $error("write strobe");
  c_word_read: cover property (rdNow && wordMode);
  c_high_read: cover property (rdNow && !wordMode && sharedPinEightIn);
  c_write: cover property (regWrStrobe);
endmodule
bind bwp_port bwp_port_checker bwp_port_checker_i (.*);

// *** dv/bwp_host_model.sv ***
// Host side wire model: resolves every bus line from device and host drivers.
// Assumes the bench sets host drive and enable; a floating line flips each cycle.
`timescale 1ns/10ps
module bwp_host_model (
  input wire logic clk,
  input wire logic [11:0] hostDrv,
  input wire logic [11:0] hostEn,
  input wire logic [11:0] devOut,
  input wire logic [11:0] devOe,
  output logic [11:0] wireLvl
);
  logic [11:0] lastLvl_reg = 12'h000;
  // Inverting a released line stops a stale level from passing as driven.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      wireLvl[i] = devOe[i] ? devOut[i] : (hostEn[i] ? hostDrv[i] : ~lastLvl_reg[i]);
    end
  end
  // Last level feeds the float pattern.
  always_ff @(posedge clk) begin
    lastLvl_reg <= wireLvl;
  end
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench of the parallel host port in word and byte mode.
// Assumes the design package, header and host wire model are compiled first.
`timescale 1ns/10ps
module tb_top;
  import bwp_pkg::*;
  logic clk = 0, rst_n = 0, csN = 1, rdN = 1, wrN = 1, wordMode = 1;
  logic [11:0] hostDrv = 12'h000, hostEn = 12'h000, wireLvl, regWrData;
  bwp_word_t resultWord = 12'hA5C;
  logic [2:0] resultChan = 3'h5;
  logic regWrStrobe, readDone;
  wire [11:0] devOut, devOe;
  int err_total = 0, total_checks = 0, n;
  // Free running clock.
  always #20 clk = ~clk;
  bwp_port bwp_port_i (.clk(clk), .rst_n(rst_n), .csN(csN), .rdN(rdN), .wrN(wrN),
    .wordMode(wordMode), .busLowBitsIn(wireLvl[7:0]), .busLowBitsOut(devOut[7:0]),
    .busLowBitsOe(devOe[7:0]), .sharedPinEightIn(wireLvl[8]),
    .sharedPinEightOut(devOut[8]), .sharedPinEightOe(devOe[8]),
    .busTopBitsIn(wireLvl[11:9]), .busTopBitsOut(devOut[11:9]),
    .busTopBitsOe(devOe[11:9]), .resultWord(resultWord), .resultChan(resultChan),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .readDone(readDone));
  bwp_host_model bwp_host_model_i (.clk(clk), .hostDrv(hostDrv), .hostEn(hostEn),
    .devOut(devOut), .devOe(devOe), .wireLvl(wireLvl));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Read with the upper byte select s; the select only reaches the pin in byte mode.
  task automatic rd(input logic s, input logic [11:0] exp, input logic [11:0] oe);
    @(posedge clk);
    hostDrv <= {3'h0, s, 8'h00};
    hostEn <= wordMode ? 12'h000 : 12'h100;
    csN <= 0;
    rdN <= 0;
    @(posedge clk);
    #1;
    chk(devOe, oe);
    chk(wordMode ? devOut : {4'h0, devOut[7:0]}, exp);
    @(posedge clk);
    csN <= 1;
    rdN <= 1;
    for (n = 0; n < 4 && readDone !== 1'b1; n++) @(posedge clk) #1;
    chk(12'(readDone), 12'h001);
    chk(devOe, 12'h000);
    if (n == 4) report_and_stop();
  endtask
  // Write d (bit 8 is the select in byte mode); data stays on the bus past release.
  task automatic wr(input logic [11:0] d, input logic stb, input logic [11:0] exp);
    @(posedge clk);
    hostDrv <= d;
    hostEn <= wordMode ? 12'hFFF : 12'h1FF;
    csN <= 0;
    wrN <= 0;
    repeat (2) @(posedge clk);
    csN <= 1;
    wrN <= 1;
    for (n = 0; n < 4 && regWrStrobe !== 1'b1; n++) @(posedge clk) #1;
    chk(12'(regWrStrobe), 12'(stb));
    if (stb) chk(regWrData, exp);
    if (n == 4 && stb) report_and_stop();
    @(posedge clk);
    hostEn <= 12'h000;
  endtask
  // Word read while the core moves on: the port must keep the word it froze.
  task automatic rd_frozen();
    @(posedge clk);
    hostEn <= 12'h000;
    csN <= 0;
    rdN <= 0;
    @(posedge clk);
    resultWord <= 12'h1E7;
    @(posedge clk) #1;
    chk(devOut, 12'hA5C);
    @(posedge clk);
    csN <= 1;
    rdN <= 1;
    for (n = 0; n < 4 && readDone !== 1'b1; n++) @(posedge clk) #1;
    chk(12'(readDone), 12'h001);
    if (n == 4) report_and_stop();
  endtask
  // Reset in mid-run clears the held low byte, so a lone upper byte write pairs with zero.
  task automatic mid_reset();
    @(posedge clk);
    rst_n <= 0;
    @(posedge clk) #1;
    chk(devOe, 12'h000);
    chk(regWrData, 12'h000);
    chk(12'({regWrStrobe, readDone}), 12'h000);
    @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
  endtask
  // Main sequence: word transfers, byte reads, a byte pair write, then a reset in mid-run.
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd(0, 12'hA5C, 12'hFFF);
    rd_frozen();
    rd(0, 12'h1E7, 12'hFFF);
    wr(12'h3C7, 1, 12'h3C7);
    wordMode <= 0;
    rd(0, 12'h0E7, 12'h0FF);
    rd(1, 12'h051, 12'h0FF);
    wr(12'h096, 0, 12'h000);
    wr(12'h10B, 1, 12'hB96);
    mid_reset();
    wr(12'h10C, 1, 12'hC00);
    report_and_stop();
  end
endmodule
